// file: shared/tmc_pkg.sv
/*
 thermometer core package: command codes, carriers, register layouts,
 power-up values and timing counts. assumes a 250 MHz core clock.
*/
package tmc_pkg;
   // command codes on the host command port
   typedef enum logic [2:0] {
      TMC_OP_BEGIN = 3'h0,
      TMC_OP_HALT = 3'h1,
      TMC_OP_FETCH = 3'h2,
      TMC_OP_UPPER = 3'h3,
      TMC_OP_LOWER = 3'h4,
      TMC_OP_SETTINGS = 3'h5
   } tmc_op_t;

   typedef struct packed {
      logic valid;
      tmc_op_t op;
      logic write;
      logic [15:0] data;
   } tmc_cmd_t;

   typedef struct packed {
      logic valid;
      logic [15:0] data;
   } tmc_rsp_t;

   // nonvolatile image: upper, lower, polarity, single-conversion bit
   typedef struct packed {
      logic [15:0] upper;
      logic [15:0] lower;
      logic output_polarity_bit;
      logic oneShot;
   } tmc_nv_t;

   typedef struct packed {
      logic valid;
      tmc_nv_t image;
   } tmc_nv_store_t;

   // sequencer states, gray along load -> idle -> convert
   typedef enum logic [1:0] {
      TMC_LOAD = 2'b00,
      TMC_IDLE = 2'b01,
      TMC_CONVERT = 2'b11
   } tmc_state_t;

   // settings_and_status field positions
   localparam int TMC_DONE_BIT = 7;
   localparam int TMC_HIGH_BIT = 6;
   localparam int TMC_LOW_BIT = 5;
   localparam int TMC_NVB_BIT = 4;
   localparam int TMC_RESH_BIT = 3;
   localparam int TMC_RESL_BIT = 2;
   localparam int TMC_POL_BIT = 1;
   localparam int TMC_ONESHOT_BIT = 0;

   // resolution select codes
   localparam logic [1:0] TMC_RES_9 = 2'h0;
   localparam logic [1:0] TMC_RES_10 = 2'h1;
   localparam logic [1:0] TMC_RES_11 = 2'h2;
   localparam logic [1:0] TMC_RES_12 = 2'h3;

   // power-up and factory values
   localparam logic [15:0] TMC_TEMP_RESET = 16'hc400;
   localparam logic [15:0] TMC_UPPER_FACTORY = 16'h0f00;
   localparam logic [15:0] TMC_LOWER_FACTORY = 16'h0a00;
   localparam logic TMC_POL_FACTORY = 1'b0;
   localparam logic TMC_ONESHOT_FACTORY = 1'b0;
   localparam logic [5:0] TMC_SETTINGS_RESET = 6'h23;

   // result masks per resolution
   localparam logic [15:0] TMC_MASK_9 = 16'hff80;
   localparam logic [15:0] TMC_MASK_10 = 16'hffc0;
   localparam logic [15:0] TMC_MASK_11 = 16'hffe0;
   localparam logic [15:0] TMC_MASK_12 = 16'hfff0;

   // timing
   localparam longint TMC_CLK_KHZ = 250000;
   localparam longint TMC_CONV9_MAX_US = 93750;
   localparam longint TMC_NV_TYP_US = 4000;
   localparam longint TMC_NV_MAX_US = 10000;
   // longest times round down
   localparam int TMC_CONV9_CYCLES = int'((TMC_CONV9_MAX_US * TMC_CLK_KHZ) / 1000);
   localparam int TMC_NV_CYCLES = int'((TMC_NV_TYP_US * TMC_CLK_KHZ) / 1000);
   localparam int TMC_NV_MAX_CYCLES = int'((TMC_NV_MAX_US * TMC_CLK_KHZ) / 1000);
   localparam int TMC_CNT_W = 28;
endpackage

// file: rtl/tmc_conv_timer.sv
/*
 conversion duration timer: counts base cycles shifted by the resolution
 code and pulses done at the end. assumes start and abort are one-cycle
 pulses from the sequencer and that start never coincides with an unfinished count.
*/
`timescale 1ns/1ps
module tmc_conv_timer
   import tmc_pkg::*;
#(
   parameter int BASE_CYCLES = TMC_CONV9_CYCLES,
   parameter int CNT_W = TMC_CNT_W
) (
   input wire logic clock, // core clock
   input wire logic rstn, // async reset, active low
   input wire logic clockEn, // freezes state while low
   input wire logic start, // begin a conversion count
   input wire logic abort, // drop a running count
   input wire logic [1:0] res, // resolution code of this conversion
   output logic done // one-cycle pulse at end of count
);
   logic [CNT_W-1:0] count_reg;
   logic running_reg;
   logic [CNT_W-1:0] span;

   // each added bit of resolution doubles the duration
   assign span = CNT_W'(BASE_CYCLES) << res; // RULE_07

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         count_reg <= '0;
         running_reg <= 1'b0;
         done <= 1'b0;
      end else if (clockEn) begin
         done <= 1'b0;
         if (abort) begin
            running_reg <= 1'b0;
         end else if (start) begin
            count_reg <= span - CNT_W'(1);
            running_reg <= 1'b1;
         end else if (running_reg) begin
            if (count_reg == '0) begin
               running_reg <= 1'b0;
               done <= 1'b1;
            end else begin
               count_reg <= count_reg - CNT_W'(1);
            end
         end
      end
   end
endmodule

// file: rtl/tmc_core.sv
/*
 thermometer and thermostat core: conversion sequencing, result format,
 trip point hysteresis, sticky flags, nonvolatile image handling and the
 host command port. assumes the converter holds a valid signed 12-bit
 code in sixteenths of a degree whenever a conversion ends, and that the
 nonvolatile image input is stable from reset until the first edge after
 its release.
*/
// Functional notes
// RULE_01: standard variant idles after power-up until a begin command.
// RULE_02: auto-start variant converts at power-up in the stored mode.
// RULE_03: continuous mode repeats until halt; begin restarts at any time; the code ignores begin while a conversion runs.
// RULE_04: single mode does one conversion per begin, then idles.
// RULE_05: resolution selectable 9 to 12 bits, half to sixteenth degree.
// RULE_06: 12-bit resolution at power-up, then follows the two select bits.
// RULE_07: conversion duration doubles per added resolution bit.
// RULE_08: each result stored as 16-bit two's complement, sign on top.
// RULE_09: result left-justified, bits below resolution and 3..0 zero.
// RULE_10: 12-bit codes: +125 is 7d00, -0.5 is ff80, -55 is c900.
// RULE_11: temperature is read-only, reached only by the fetch command.
// RULE_12: thermostat output updates only when a conversion completes; the code also moves the pin whenever the polarity bit changes.
// RULE_13: output active at result >= upper, inactive once below lower.
// RULE_14: polarity bit in settings chooses the output active level.
// RULE_15: host writes trip points in the same signed 16-bit layout.
// RULE_16: trip points masked to resolution on read and on compare.
// RULE_17: trip points nonvolatile, accessed by their own commands.
// RULE_18: host should halt continuous conversion before changing trips.
// RULE_19: high and low flags sticky, power up 0, cleared by writing 0.
// RULE_20: temperature register powers up holding minus sixty degrees.
// RULE_21: factory trip points are 15 and 10 degrees.
// RULE_22: settings power up 100011 followed by the two stored bits.
// RULE_23: nonvolatile write completes within 10 ms, 4 ms typical.
// RULE_24: select code 00..11 is 9..12 bits, 9-bit max 93.75 ms.
// RULE_25: polarity 1 makes the output active high, 0 active low.
// RULE_26: busy bit reads 1 during a nonvolatile write, else 0.
// RULE_27: done bit 0 during conversion, 1 when complete, powers up 1.
// RULE_28: trip comparisons are signed on the bits kept at resolution.
`timescale 1ns/1ps
module tmc_core
   import tmc_pkg::*;
#(
   parameter bit AUTO_START = 1'b0,
   parameter int CONV_BASE_CYCLES = TMC_CONV9_CYCLES,
   parameter int NV_WRITE_CYCLES = TMC_NV_CYCLES
) (
   input wire logic clock, // core clock, 250 MHz
   input wire logic rstn, // async power-on reset, active low
   input wire logic clockEn, // freezes all state while low
   input wire tmc_cmd_t cmd, // host command, valid for one cycle
   input wire logic [11:0] adcCode, // converter code, sixteenths of a degree
   input wire tmc_nv_t nvImage, // stored image, read after reset
   output tmc_rsp_t rsp, // read answer, valid for one cycle
   output tmc_nv_store_t nvStore, // image to commit to nonvolatile store
   output logic converting, // high while a conversion runs
   output logic thermostatOut // thermostat output pin level
);
   localparam int NV_W = $clog2(NV_WRITE_CYCLES + 1);

   tmc_state_t state_reg;
   logic [15:0] temp_reg;
   logic [15:0] upper_reg;
   logic [15:0] lower_reg;
   logic pol_reg;
   logic oneShot_reg;
   logic [1:0] res_reg;
   logic [1:0] convRes_reg;
   logic done_reg;
   logic highFlag_reg;
   logic lowFlag_reg;
   logic active_reg;
   logic [NV_W-1:0] nvCount_reg;
   logic nvBusy;
   logic convStart;
   logic convAbort;
   logic convDone;
   logic [15:0] result;
   logic [15:0] mask;
   logic [15:0] convMask;
   logic cmdBegin;
   logic cmdHalt;
   logic cfgWrite;
   logic nvWrite;
   logic highSet;
   logic lowSet;

   function automatic logic [15:0] resMask(input logic [1:0] code);
      logic [15:0] m;
      m = TMC_MASK_12;
      unique case (code) // RULE_24
         TMC_RES_9: m = TMC_MASK_9;
         TMC_RES_10: m = TMC_MASK_10;
         TMC_RES_11: m = TMC_MASK_11;
         TMC_RES_12: m = TMC_MASK_12;
      endcase
      return m;
   endfunction

   assign mask = resMask(res_reg);
   assign convMask = resMask(convRes_reg);
   // left-justified, low nibble hardwired zero, unused lsbs cleared
   assign result = {adcCode, 4'h0} & convMask; // RULE_08 RULE_09 RULE_05 RULE_10
   assign cmdBegin = cmd.valid && cmd.op == TMC_OP_BEGIN;
   assign cmdHalt = cmd.valid && cmd.op == TMC_OP_HALT;
   assign cfgWrite = cmd.valid && cmd.write && cmd.op == TMC_OP_SETTINGS;
   assign nvBusy = nvCount_reg != '0;
   // a nonvolatile write arriving while busy is dropped
   assign nvWrite = !nvBusy && cmd.valid && cmd.write &&
      (cmd.op == TMC_OP_UPPER || cmd.op == TMC_OP_LOWER || cmd.op == TMC_OP_SETTINGS);
   // signed compares on the bits retained at the conversion resolution
   assign highSet = $signed(result) > $signed(upper_reg & convMask); // RULE_28 RULE_19
   assign lowSet = $signed(result) < $signed(lower_reg & convMask); // RULE_28 RULE_19

   // conversion sequencing
   always_comb begin
      convStart = 1'b0;
      convAbort = 1'b0;
      unique case (state_reg)
         TMC_LOAD: convStart = AUTO_START; // RULE_02 RULE_01
         TMC_IDLE: convStart = cmdBegin; // RULE_01 RULE_04
         TMC_CONVERT: begin
            convAbort = cmdHalt; // RULE_03
            convStart = convDone && !oneShot_reg && !cmdHalt; // RULE_03
         end
      endcase
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         state_reg <= TMC_LOAD;
      end else if (clockEn) begin
         unique case (state_reg)
            TMC_LOAD: state_reg <= AUTO_START ? TMC_CONVERT : TMC_IDLE; // RULE_02
            TMC_IDLE: if (cmdBegin) begin
               state_reg <= TMC_CONVERT;
            end
            TMC_CONVERT: begin
               if (cmdHalt) begin
                  state_reg <= TMC_IDLE; // RULE_03
               end else if (convDone && oneShot_reg) begin
                  state_reg <= TMC_IDLE; // RULE_04
               end
            end
         endcase
      end
   end

   // resolution is frozen per conversion so a late change cannot skew it
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         convRes_reg <= TMC_RES_12;
         done_reg <= 1'b1;
         converting <= 1'b0;
      end else if (clockEn) begin
         if (convStart) begin
            convRes_reg <= res_reg; // RULE_06
            done_reg <= 1'b0; // RULE_27
            converting <= 1'b1;
         end else if (convDone || convAbort) begin
            done_reg <= convDone || done_reg; // RULE_27
            converting <= 1'b0;
         end
      end
   end

   tmc_conv_timer #(
      .BASE_CYCLES(CONV_BASE_CYCLES),
      .CNT_W(TMC_CNT_W)
   ) convTimer (
      .clock(clock),
      .rstn(rstn),
      .clockEn(clockEn),
      .start(convStart),
      .abort(convAbort),
      .res(state_reg == TMC_LOAD ? TMC_RES_12 : res_reg), // RULE_06 RULE_07
      .done(convDone)
   );

   // result register
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         temp_reg <= TMC_TEMP_RESET; // RULE_20
      end else if (clockEn && convDone && !convAbort) begin
         temp_reg <= result; // RULE_08
      end
   end

   // thermostat hysteresis, evaluated only at conversion end
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         active_reg <= 1'b0;
         thermostatOut <= 1'b1;
      end else if (clockEn) begin
         if (convDone && !convAbort) begin
            if (!($signed(result) < $signed(upper_reg & convMask))) begin
               active_reg <= 1'b1; // RULE_13 RULE_12 RULE_28
            end else if (lowSet) begin
               active_reg <= 1'b0; // RULE_13 RULE_12
            end
         end
         thermostatOut <= pol_reg ? active_reg : !active_reg; // RULE_14 RULE_25
      end
   end

   // sticky flags: a set in the same cycle as a clearing write wins
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         highFlag_reg <= 1'b0;
         lowFlag_reg <= 1'b0;
      end else if (clockEn) begin
         if (convDone && !convAbort && highSet) begin
            highFlag_reg <= 1'b1; // RULE_19
         end else if (cfgWrite && !cmd.data[TMC_HIGH_BIT]) begin
            highFlag_reg <= 1'b0; // RULE_19
         end
         if (convDone && !convAbort && lowSet) begin
            lowFlag_reg <= 1'b1; // RULE_19
         end else if (cfgWrite && !cmd.data[TMC_LOW_BIT]) begin
            lowFlag_reg <= 1'b0; // RULE_19
         end
      end
   end

   // volatile resolution select
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         res_reg <= TMC_RES_12; // RULE_06 RULE_22
      end else if (clockEn && cfgWrite) begin
         res_reg <= cmd.data[TMC_RESH_BIT:TMC_RESL_BIT]; // RULE_06
      end
   end

   // nonvolatile image: loaded once after reset release, then host writes
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         upper_reg <= TMC_UPPER_FACTORY; // RULE_21
         lower_reg <= TMC_LOWER_FACTORY; // RULE_21
         pol_reg <= TMC_POL_FACTORY;
         oneShot_reg <= TMC_ONESHOT_FACTORY;
      end else if (clockEn) begin
         if (state_reg == TMC_LOAD) begin
            upper_reg <= nvImage.upper; // RULE_17 RULE_22
            lower_reg <= nvImage.lower; // RULE_17
            pol_reg <= nvImage.output_polarity_bit; // RULE_22
            oneShot_reg <= nvImage.oneShot; // RULE_22
         end else if (nvWrite) begin
            unique case (cmd.op)
               TMC_OP_UPPER: upper_reg <= cmd.data; // RULE_17 RULE_15
               TMC_OP_LOWER: lower_reg <= cmd.data; // RULE_17 RULE_15
               default: begin
                  pol_reg <= cmd.data[TMC_POL_BIT];
                  oneShot_reg <= cmd.data[TMC_ONESHOT_BIT];
               end
            endcase
         end
      end
   end

   // write-cycle busy timer and commit strobe
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         nvCount_reg <= '0;
         nvStore <= '0;
      end else if (clockEn) begin
         nvStore.valid <= 1'b0;
         if (nvWrite && state_reg != TMC_LOAD) begin
            nvCount_reg <= NV_W'(NV_WRITE_CYCLES); // RULE_23 RULE_26
            nvStore.valid <= 1'b1;
            nvStore.image.upper <= cmd.op == TMC_OP_UPPER ? cmd.data : upper_reg;
            nvStore.image.lower <= cmd.op == TMC_OP_LOWER ? cmd.data : lower_reg;
            nvStore.image.output_polarity_bit <= cmd.op == TMC_OP_SETTINGS ? cmd.data[TMC_POL_BIT] : pol_reg;
            nvStore.image.oneShot <= cmd.op == TMC_OP_SETTINGS ?
               cmd.data[TMC_ONESHOT_BIT] : oneShot_reg;
         end else if (nvBusy) begin
            nvCount_reg <= nvCount_reg - NV_W'(1); // RULE_26
         end
      end
   end

   // read answers; the temperature has no write path at all
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         rsp <= '0;
      end else if (clockEn) begin
         rsp.valid <= 1'b0;
         if (cmd.valid && !cmd.write) begin
            unique case (cmd.op)
               TMC_OP_FETCH: begin
                  rsp.valid <= 1'b1;
                  rsp.data <= temp_reg; // RULE_11
               end
               TMC_OP_UPPER: begin
                  rsp.valid <= 1'b1;
                  rsp.data <= upper_reg & mask; // RULE_16
               end
               TMC_OP_LOWER: begin
                  rsp.valid <= 1'b1;
                  rsp.data <= lower_reg & mask; // RULE_16
               end
               TMC_OP_SETTINGS: begin
                  rsp.valid <= 1'b1;
                  rsp.data <= {8'h00, done_reg, highFlag_reg, lowFlag_reg, nvBusy,
                     res_reg, pol_reg, oneShot_reg}; // RULE_27 RULE_26
               end
               default: rsp.valid <= 1'b0;
            endcase
         end
      end
   end
endmodule

// file: bench/tmc_core_sva.sv
/*
 port checker for the thermometer core.
 assumes commands are one-cycle pulses; bound to both core variants.
*/
`timescale 1ns/1ps
module tmc_core_sva
   import tmc_pkg::*;
#(
   parameter bit AUTO_START = 1'b0 // variant of the bound core
) (
   input wire logic clock, // clock
   input wire logic rstn, // reset
   input wire logic clockEn, // enable
   input wire tmc_cmd_t cmd, // command
   input wire logic [11:0] adcCode, // code
   input wire tmc_nv_t nvImage, // image
   input wire tmc_rsp_t rsp, // answer
   input wire tmc_nv_store_t nvStore, // commit
   input wire logic converting, // busy
   input wire logic thermostatOut // pin
);
   logic loaded_reg; // load cycle ignores commands
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         loaded_reg <= 1'b0;
      end else if (clockEn) begin
         loaded_reg <= 1'b1;
      end
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);
   sequence s_take(tmc_op_t o);
      loaded_reg && clockEn && cmd.valid && cmd.op == o;
   endsequence
   property p_read_answer;
      s_take(TMC_OP_FETCH) ##0 !cmd.write |=> rsp.valid;
   endproperty
   a_read_answer: assert property (p_read_answer) else $error("no read answer");
   property p_fetch_low;
      rsp.valid && $past(cmd.op == TMC_OP_FETCH) |-> rsp.data[3:0] == 4'h0;
   endproperty
   a_fetch_low: assert property (p_fetch_low) else $error("low nibble set");
   property p_nv_cause;
      nvStore.valid |-> $past(cmd.valid && cmd.write && cmd.op >= TMC_OP_UPPER);
   endproperty
   a_nv_cause: assert property (p_nv_cause) else $error("commit without write");
   property p_nv_upper;
      nvStore.valid && $past(cmd.op == TMC_OP_UPPER) |-> nvStore.image.upper == $past(cmd.data);
   endproperty
   a_nv_upper: assert property (p_nv_upper) else $error("wrong upper image");
   property p_busy;
      nvStore.valid ##1 s_take(TMC_OP_SETTINGS) ##0 !cmd.write |=> rsp.data[TMC_NVB_BIT];
   endproperty
   a_busy: assert property (p_busy) else $error("busy bit low");
   property p_begin;
      s_take(TMC_OP_BEGIN) ##0 !converting |=> converting;
   endproperty
   a_begin: assert property (p_begin) else $error("begin ignored");
   property p_halt;
      s_take(TMC_OP_HALT) |=> !converting [*2];
   endproperty
   a_halt: assert property (p_halt) else $error("halt ignored");
   property p_start_cause;
      $rose(converting) |-> $past(cmd.valid && cmd.op == TMC_OP_BEGIN) ||
         (AUTO_START && !$past(loaded_reg));
   endproperty
   a_start_cause: assert property (p_start_cause) else $error("unasked start");
   property p_power_up;
      $rose(loaded_reg) |-> converting == AUTO_START;
   endproperty
   a_power_up: assert property (p_power_up) else $error("wrong power-up mode");
   property p_thermostat_output_hold;
      $changed(thermostatOut) |-> !$past(rstn, 3) || $past(converting) ||
         $past(converting, 2) || $past(cmd.valid) || $past(cmd.valid, 2);
   endproperty
   a_thermostat_output_hold: assert property (p_thermostat_output_hold) else $error("pin moved");
endmodule
bind tmc_core tmc_core_sva #(.AUTO_START(AUTO_START)) i_sva (.clock(clock), .rstn(rstn),
   .clockEn(clockEn), .cmd(cmd),
   .adcCode(adcCode), .nvImage(nvImage), .rsp(rsp), .nvStore(nvStore),
   .converting(converting), .thermostatOut(thermostatOut));

// file: bench/tmc_host_model.sv
/*
 host model: issues one command per call on the command port.
 assumes the core answers reads within a few cycles.
*/
`timescale 1ns/1ps
module tmc_host_model
   import tmc_pkg::*;
(
   input wire logic clock, // clock
   output tmc_cmd_t cmd, // command
   input wire tmc_rsp_t rsp // answer
);
   initial cmd = '0;
   // trip words go out as given: signed, sign on bit 15
   task automatic send(input tmc_op_t op, input logic wr, input logic [15:0] d);
      @(posedge clock);
      cmd <= '{1'b1, op, wr, d};
      @(posedge clock);
      cmd.valid <= 1'b0;
      cmd.data <= ~d; // released payload must not look valid
      #1;
   endtask
   task automatic read(input tmc_op_t op, output logic [15:0] d, output bit ok);
      send(op, 1'b0, 16'h0000);
      ok = 0;
      d = 'x;
      for (int n = 0; n < 4 && !ok; n++) begin
         if (rsp.valid === 1'b1) begin
            ok = 1;
            d = rsp.data;
         end else begin
            @(posedge clock);
            #1;
         end
      end
   endtask
endmodule

// file: bench/testbench.sv
/*
 self-checking bench for the thermometer core.
 assumes short counts: 8-cycle base conversion, 8-cycle store write.
 an auto-start twin shares the command port and the stored image.
*/
`timescale 1ns/1ps
`define TMC_CHECK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin num_errors++; \
   $display("MISMATCH %s exp=%h got=%h", nm, e, g); end end
module testbench
   import tmc_pkg::*;
;
   logic clock = 1'b0;
   logic rstn = 1'b0;
   logic clockEn = 1'b1;
   logic [11:0] adcCode = 12'h000;
   tmc_nv_t nvImage = '{16'h0f00, 16'h0a00, 1'b0, 1'b0};
   tmc_cmd_t cmd;
   tmc_rsp_t rsp;
   tmc_nv_store_t nvStore;
   logic converting;
   logic thermostatOut;
   int num_errors = 0;
   int samples_checked = 0;
   int resM = 3, polM = 0, shotM = 0, actM = 0, hiM = 0, loM = 0, n;
   int dur [4];
   logic [15:0] upM = 16'h0f00;
   logic [15:0] lwM = 16'h0a00;
   logic [15:0] tempM;
   logic [15:0] rd;
   bit ok;
   logic [11:0] adcQ[$] = '{12'h7d0, 12'hff8, 12'hc90, 12'h000};
   logic [11:0] hystQ[$] = '{12'h0f4, 12'h0c0, 12'h09f, 12'h0a0, 12'h0f3, 12'h100};

   initial forever #2 clock = ~clock;

   tmc_core #(.AUTO_START(1'b0), .CONV_BASE_CYCLES(8), .NV_WRITE_CYCLES(8)) i_dut (
      .clock(clock), .rstn(rstn), .clockEn(clockEn), .cmd(cmd), .adcCode(adcCode),
      .nvImage(nvImage), .rsp(rsp), .nvStore(nvStore), .converting(converting),
      .thermostatOut(thermostatOut));
   tmc_host_model i_host (.clock(clock), .cmd(cmd), .rsp(rsp));
   logic convA;
   // only its power-up behaviour is compared; the checker watches the rest
   tmc_core #(.AUTO_START(1'b1), .CONV_BASE_CYCLES(8), .NV_WRITE_CYCLES(8)) i_dut_auto (
      .clock(clock), .rstn(rstn), .clockEn(clockEn), .cmd(cmd), .adcCode(adcCode),
      .nvImage(nvImage), .rsp(), .nvStore(), .converting(convA),
      .thermostatOut());

   // the bench plays the nonvolatile store across resets
   always @(posedge clock) if (nvStore.valid === 1'b1) nvImage <= nvStore.image;

   function automatic logic [15:0] msk(input int r);
      return 16'hfff0 << (3 - r);
   endfunction

   task automatic final_report();
      $display("checks %0d errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   task automatic do_reset();
      @(posedge clock);
      rstn <= 1'b0;
      repeat (10) @(posedge clock);
      rstn <= 1'b1;
      repeat (3) @(posedge clock);
      tempM = 16'hc400;
      resM = 3;
      hiM = 0;
      loM = 0;
      actM = 0;
   endtask

   task automatic model_conv(input logic [11:0] a);
      logic [15:0] t;
      t = {a, 4'h0} & msk(resM);
      tempM = t;
      if ($signed(t) >= $signed(upM & msk(resM))) actM = 1;
      else if ($signed(t) < $signed(lwM & msk(resM))) actM = 0;
      if ($signed(t) > $signed(upM & msk(resM))) hiM = 1;
      if ($signed(t) < $signed(lwM & msk(resM))) loM = 1;
   endtask

   task automatic rd_chk(input tmc_op_t op, input logic [15:0] e);
      i_host.read(op, rd, ok);
      if (!ok) begin
         num_errors++;
         final_report();
      end
      `TMC_CHECK(op.name(), e, rd)
   endtask

   task automatic check_all();
      rd_chk(TMC_OP_FETCH, tempM);
      rd_chk(TMC_OP_UPPER, upM & msk(resM));
      rd_chk(TMC_OP_LOWER, lwM & msk(resM));
      rd_chk(TMC_OP_SETTINGS, {9'h001, hiM[0], loM[0], 1'b0, resM[1:0], polM[0], shotM[0]});
      `TMC_CHECK("thermostatOut", polM[0] ? actM[0] : !actM[0], thermostatOut)
   endtask

   task automatic set_cfg(input int r, input int p, input int s);
      // ones on the flag bits leave the sticky flags alone
      i_host.send(TMC_OP_SETTINGS, 1'b1, {9'h001, 2'b11, 1'b0, r[1:0], p[0], s[0]});
      resM = r;
      polM = p;
      shotM = s;
      repeat (12) @(posedge clock);
   endtask

   task automatic wr_trip(input tmc_op_t op, input logic [15:0] d);
      i_host.send(op, 1'b1, d);
      if (op == TMC_OP_UPPER) upM = d;
      else lwM = d;
      repeat (12) @(posedge clock);
   endtask

   task automatic convert(input logic [11:0] a, output int d);
      @(posedge clock);
      adcCode <= a;
      i_host.send(TMC_OP_BEGIN, 1'b0, 16'h0000);
      d = 0;
      while (converting === 1'b1 && d < 3000) begin
         @(posedge clock);
         #1;
         d++;
      end
      if (d == 0 || d >= 3000) begin
         num_errors++;
         final_report();
      end
      model_conv(a);
      repeat (3) @(posedge clock);
      check_all();
   endtask

   initial begin
      repeat (100000) @(posedge clock);
      num_errors++;
      final_report();
   end

   initial begin
      void'($urandom(32'h2076_1614));
      do_reset();
      repeat (40) @(posedge clock);
      `TMC_CHECK("idle", 1'b0, converting)
      `TMC_CHECK("autostart", 1'b1, convA)
      check_all();
      for (int r = 0; r < 4; r++) begin
         set_cfg(r, 1, 1);
         adcQ[3] = 12'($urandom);
         foreach (adcQ[k]) convert(adcQ[k], dur[r]);
         repeat (30) @(posedge clock);
         `TMC_CHECK("single", 1'b0, converting)
      end
      for (int r = 1; r < 4; r++) `TMC_CHECK("span", 8 * ((1 << r) - 1), dur[r] - dur[0])
      wr_trip(TMC_OP_UPPER, 16'h0f4f);
      set_cfg(0, 1, 1);
      check_all();
      set_cfg(3, 0, 1);
      foreach (hystQ[k]) convert(hystQ[k], n);
      wr_trip(TMC_OP_LOWER, 16'hff80);
      wr_trip(TMC_OP_UPPER, 16'h0010);
      convert(12'hfe0, n);
      convert(12'h001, n);
      for (int k = 0; k < 16; k++) begin
         set_cfg($urandom % 4, $urandom % 2, 1);
         convert(12'h080 + 12'($urandom % 160), n);
      end
      i_host.send(TMC_OP_SETTINGS, 1'b1, {12'h000, resM[1:0], polM[0], shotM[0]});
      hiM = 0;
      loM = 0;
      repeat (12) @(posedge clock);
      check_all();
      i_host.send(TMC_OP_UPPER, 1'b1, 16'h1230);
      upM = 16'h1230;
      i_host.read(TMC_OP_SETTINGS, rd, ok);
      `TMC_CHECK("busy", 1'b1, rd[4])
      // a low enable must hold the store-write countdown
      @(posedge clock);
      clockEn <= 1'b0;
      repeat (20) @(posedge clock);
      clockEn <= 1'b1;
      i_host.read(TMC_OP_SETTINGS, rd, ok);
      `TMC_CHECK("frozen busy", 1'b1, rd[4])
      i_host.send(TMC_OP_LOWER, 1'b1, 16'h0550);
      i_host.send(TMC_OP_FETCH, 1'b1, 16'h1234);
      repeat (12) @(posedge clock);
      check_all();
      set_cfg(0, 1, 0);
      @(posedge clock);
      adcCode <= 12'h123;
      i_host.send(TMC_OP_BEGIN, 1'b0, 16'h0000);
      repeat (40) @(posedge clock);
      `TMC_CHECK("running", 1'b1, converting)
      model_conv(12'h123);
      i_host.send(TMC_OP_HALT, 1'b0, 16'h0000);
      repeat (30) @(posedge clock);
      `TMC_CHECK("halted", 1'b0, converting)
      rd_chk(TMC_OP_FETCH, tempM);
      i_host.send(TMC_OP_BEGIN, 1'b0, 16'h0000);
      `TMC_CHECK("restart", 1'b1, converting)
      i_host.send(TMC_OP_HALT, 1'b0, 16'h0000);
      do_reset();
      check_all();
      final_report();
   end
endmodule
